// file: spi_link_cfg.svh
`ifndef SPI_LINK_CFG_SVH
`define SPI_LINK_CFG_SVH
`define CMD_WRITE      8'h00
`define CMD_READ       8'h80
`define FIFO_DATA_ADDR 8'h08
`define FRAME_BITS     6'h18
`define FETCH_BIT      6'h10
`define WORD_BITS      6'h18
`define BURST_LAST     6'h27
`define SCLK_HALF_DIV  4'h4
`endif

// file: spi_link_pkg.sv
package spi_link_pkg;
  typedef enum logic [1:0] {H_IDLE, H_RUN, H_GAP} host_state_t;
  typedef struct packed {
    logic [5:0]  bit_cnt;
    logic [7:0]  addr;
    logic [7:0]  cmd;
    logic [7:0]  data;
    logic        burst;
    logic        done;
  } rx_t;
endpackage

// file: spi_link_if.sv
`timescale 1ns/10ps
interface spi_link_if;
  logic sclk;
  logic chip_select_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  modport dev  (input sclk, chip_select_n, mosi, output miso, miso_oe);
  modport host (output sclk, chip_select_n, mosi, input miso, miso_oe);
endinterface

// file: sync2.sv
`timescale 1ns/10ps
module sync2 (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic d,
  output logic      q
);
  logic [1:0] s_reg;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_reg <= 2'h0;
    end else begin
      s_reg <= {s_reg[0], d};
    end
  end
  assign q = s_reg[1];
endmodule

// file: spi_target.sv
`timescale 1ns/10ps
`include "spi_link_cfg.svh"
module spi_target import spi_link_pkg::*; #(
  parameter logic [7:0] CMD_WRITE = `CMD_WRITE,
  parameter logic [7:0] CMD_READ  = `CMD_READ
) (
  input  wire logic  clk,
  input  wire logic  rst_b,
  spi_link_if.dev    link,
  output logic       wr_valid,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic [7:0] rd_addr,
  input  wire logic [7:0]  rd_data,
  input  wire logic [23:0] fifo_word,
  output logic       fifo_pop
);
  // Link-side receive state, sclk domain, cleared while deselected
  rx_t  rx_reg, rx_next;
  logic [23:0] tx_reg;
  logic        tog_reg, pop_tog_reg;
  logic        wr_sync, pop_sync;
  logic        wr_prev_reg, pop_prev_reg;
  logic [7:0]  rd_addr_reg;
  logic [23:0] fifo_hold_reg;
  logic [15:0] wr_hold_reg;

  always_comb begin
    rx_next = rx_reg;
    if (!rx_reg.done) begin
      rx_next.bit_cnt = rx_reg.bit_cnt + 6'h01;
      if (rx_reg.bit_cnt < 6'h08) begin
        rx_next.addr = {rx_reg.addr[6:0], link.mosi};
      end else if (rx_reg.bit_cnt < `FETCH_BIT) begin
        rx_next.cmd = {rx_reg.cmd[6:0], link.mosi};
      end else begin
        rx_next.data = {rx_reg.data[6:0], link.mosi};
      end
      if (rx_reg.bit_cnt == `FETCH_BIT - 6'h01 &&
          {rx_reg.cmd[6:0], link.mosi} == CMD_READ &&
          rx_reg.addr == `FIFO_DATA_ADDR) begin
        rx_next.burst = 1'b1;
      end
      if (!rx_reg.burst && rx_reg.bit_cnt == `FRAME_BITS - 6'h01) begin
        rx_next.done = 1'b1;
      end
      if (rx_reg.burst && rx_reg.bit_cnt == `BURST_LAST) begin
        rx_next.bit_cnt = `FETCH_BIT;
      end
    end
  end

  // Async select clear gives reset of counter on each frame
  always_ff @(posedge link.sclk or posedge link.chip_select_n) begin
    if (link.chip_select_n) begin
      rx_reg <= '0;
      tog_reg <= 1'b0;
      pop_tog_reg <= 1'b0;
    end else begin
      rx_reg <= rx_next;
      if (!rx_reg.done && rx_reg.bit_cnt == `FRAME_BITS - 6'h01 &&
          rx_reg.cmd == CMD_WRITE) begin
        tog_reg <= ~tog_reg;
      end
      // Pop as each word starts; the head is loaded before it advances
      if (!rx_reg.done && rx_next.burst &&
          rx_next.bit_cnt == `FETCH_BIT) begin
        pop_tog_reg <= ~pop_tog_reg;
      end
    end
  end

  // Write payload held in the link domain, not cleared by deselect
  always_ff @(posedge link.sclk) begin
    if (!rx_reg.done && rx_reg.bit_cnt == `FRAME_BITS - 6'h01 &&
        rx_reg.cmd == CMD_WRITE) begin
      wr_hold_reg <= {rx_reg.addr, rx_next.data};
    end
  end

  // Falling-edge shifter; loads the fetched word after bit 16
  always_ff @(negedge link.sclk or posedge link.chip_select_n) begin
    if (link.chip_select_n) begin
      tx_reg <= 24'h000000;
    end else if (rx_reg.bit_cnt == `FETCH_BIT &&
                 !rx_reg.done) begin
      if (rx_reg.burst) begin
        tx_reg <= fifo_hold_reg;
      end else if (rx_reg.cmd == CMD_READ) begin
        tx_reg <= {rd_data, 16'h0000};
      end else begin
        tx_reg <= 24'h000000;
      end
    end else begin
      tx_reg <= {tx_reg[22:0], 1'b0};
    end
  end

  assign link.miso    = tx_reg[23];
  assign link.miso_oe = ~link.chip_select_n;

  // Core domain: address and data are stable once the toggle has crossed
  sync2 wr_s (.clk(clk), .rst_b(rst_b), .d(tog_reg), .q(wr_sync));
  sync2 pp_s (.clk(clk), .rst_b(rst_b), .d(pop_tog_reg), .q(pop_sync));

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_prev_reg <= 1'b0;
      pop_prev_reg <= 1'b0;
      wr_valid <= 1'b0;
      fifo_pop <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
      rd_addr_reg <= 8'h00;
      fifo_hold_reg <= 24'h000000;
    end else begin
      wr_prev_reg <= wr_sync;
      pop_prev_reg <= pop_sync;
      wr_valid <= wr_sync ^ wr_prev_reg;
      fifo_pop <= pop_sync ^ pop_prev_reg;
      if (wr_sync ^ wr_prev_reg) begin
        wr_addr <= wr_hold_reg[15:8];
        wr_data <= wr_hold_reg[7:0];
      end
      rd_addr_reg <= rx_reg.addr;
      fifo_hold_reg <= fifo_word;
    end
  end
  assign rd_addr = rd_addr_reg;
endmodule

// file: spi_host.sv
`timescale 1ns/10ps
`include "spi_link_cfg.svh"
module spi_host import spi_link_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst_b,
  spi_link_if.host         link,
  input  wire logic        req,
  input  wire logic [7:0]  req_addr,
  input  wire logic [7:0]  req_cmd,
  input  wire logic [7:0]  req_data,
  input  wire logic [7:0]  req_words,
  output logic             busy,
  output logic             rx_valid,
  output logic [23:0]      rx_word
);
  typedef struct packed {
    host_state_t st;
    logic [3:0]  div;
    logic        sclk;
    logic        cs_n;
    logic [15:0] hdr;
    logic [7:0]  wdata;
    logic [5:0]  cnt;
    logic [7:0]  words;
    logic [23:0] sh;
    logic        valid;
    logic        busy;
    logic        burst;
  } host_t;
  host_t s_reg, s_next;
  logic  miso_s;
  sync2 ms (.clk(clk), .rst_b(rst_b), .d(link.miso), .q(miso_s));

  always_comb begin
    s_next = s_reg;
    s_next.valid = 1'b0;
    case (s_reg.st)
      H_IDLE: begin
        if (req) begin
          s_next.st = H_RUN;
          s_next.cs_n = 1'b0;
          s_next.busy = 1'b1;
          s_next.hdr = {req_addr, req_cmd};
          s_next.wdata = req_data;
          s_next.burst = (req_addr == `FIFO_DATA_ADDR) &&
                         (req_cmd == `CMD_READ);
          s_next.words = (req_addr == `FIFO_DATA_ADDR) ? req_words : 8'h01;
          s_next.cnt = 6'h00;
          s_next.div = 4'h0;
        end
      end
      H_RUN: begin
        s_next.div = s_reg.div + 4'h1;
        if (s_reg.div == `SCLK_HALF_DIV - 4'h1) begin
          s_next.div = 4'h0;
          s_next.sclk = ~s_reg.sclk;
          if (!s_reg.sclk) begin
            s_next.sh = {s_reg.sh[22:0], miso_s};
          end else begin
            s_next.cnt = s_reg.cnt + 6'h01;
            if (s_reg.cnt < `FETCH_BIT) begin
              s_next.hdr = {s_reg.hdr[14:0], 1'b0};
            end else begin
              s_next.wdata = {s_reg.wdata[6:0], 1'b0};
            end
            if (s_reg.cnt == `BURST_LAST ||
                (!s_reg.burst && s_reg.cnt == `FRAME_BITS - 6'h01)) begin
              s_next.valid = 1'b1;
              s_next.words = s_reg.words - 8'h01;
              s_next.cnt = `FETCH_BIT;
              if (s_reg.words <= 8'h01) begin
                s_next.st = H_GAP;
              end
            end
          end
        end
      end
      default: begin
        s_next.cs_n = 1'b1;
        s_next.div = s_reg.div + 4'h1;
        if (s_reg.div == `SCLK_HALF_DIV) begin
          s_next.st = H_IDLE;
          s_next.busy = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_reg <= '{st: H_IDLE, cs_n: 1'b1, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.sclk          = s_reg.sclk;
  assign link.chip_select_n = s_reg.cs_n;
  assign link.mosi = (s_reg.cnt < `FETCH_BIT) ? s_reg.hdr[15] : s_reg.wdata[7];
  assign busy      = s_reg.busy;
  assign rx_valid  = s_reg.valid;
  assign rx_word   = s_reg.sh;
endmodule

// file: spi_link_sva.sv
`timescale 1ns/10ps
module spi_link_sva (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  logic [7:0] rise_reg;
  always_ff @(posedge clk) begin
    if (chip_select_n) begin
      rise_reg <= 8'h00;
    end else if ($rose(sclk)) begin
      rise_reg <= rise_reg + 8'h01;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence half_high; sclk [*4] ##1 !sclk; endsequence
  sequence quiet_gap; chip_select_n [*5]; endsequence
  sclk_idle_a: assert property (chip_select_n |-> !sclk)
    else $error("sclk moved while deselected");
  mosi_hold_a: assert property ($rose(sclk) |-> $stable(mosi))
    else $error("mosi changed at sampling edge");
  miso_fall_a: assert property (miso_oe && $past(miso_oe) && !$fell(sclk)
    |-> $stable(miso))
    else $error("miso changed off the falling edge");
  sclk_half_a: assert property ($rose(sclk) |-> half_high)
    else $error("sclk half period wrong");
  frame_len_a: assert property ($rose(chip_select_n) |-> rise_reg == 8'h18
    || (rise_reg > 8'h10 && (rise_reg - 8'h10) % 8'h18 == 8'h00))
    else $error("frame clock count wrong");
  gap_len_a: assert property ($rose(chip_select_n) |-> quiet_gap)
    else $error("reselect too soon");
  oe_off_a: assert property (chip_select_n && $past(chip_select_n)
    |-> !miso_oe)
    else $error("miso driven while deselected");
  setup_a: assert property ($fell(chip_select_n) |-> !sclk ##1 !sclk)
    else $error("sclk rose at select");
endmodule

// file: tb.sv
`timescale 1ns/10ps
`include "spi_link_cfg.svh"
module tb;
  import spi_link_pkg::*;
  typedef struct packed {
    logic [7:0]  a;
    logic [7:0]  c;
    logic [7:0]  d;
    logic [7:0]  n;
    logic        w;
    logic [23:0] ex;
  } row_t;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        req = 1'b0;
  row_t        cur = '0;
  logic [7:0]  pops = 8'h00;
  logic        wr_seen = 1'b0;
  logic        wr_valid, fifo_pop, busy, rx_valid;
  logic [7:0]  wr_addr, wr_data, rd_addr;
  logic [23:0] rx_word;
  int          n_errors = 0;
  int          tests_run = 0;
  row_t        rows [5] = '{
    '{8'h12, `CMD_WRITE, 8'h3C, 8'h00, 1'b1, 24'h0},
    '{8'hFF, `CMD_WRITE, 8'h00, 8'h00, 1'b1, 24'h0},
    '{8'h21, `CMD_READ, 8'h00, 8'h00, 1'b0, 24'h84},
    '{8'h40, 8'h55, 8'h77, 8'h00, 1'b0, 24'h0},
    '{`FIFO_DATA_ADDR, `CMD_READ, 8'h00, 8'h03, 1'b0, 24'h105A02}};
  spi_link_if link ();
  spi_target u_spi_target (.clk(clk), .rst_b(rst_b), .link(link),
    .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_addr(rd_addr), .rd_data(rd_addr ^ 8'hA5),
    .fifo_word({16'h105A, pops}), .fifo_pop(fifo_pop));
  spi_host u_spi_host (.clk(clk), .rst_b(rst_b), .link(link), .req(req),
    .req_addr(cur.a), .req_cmd(cur.c), .req_data(cur.d),
    .req_words(cur.n), .busy(busy), .rx_valid(rx_valid),
    .rx_word(rx_word));
  spi_link_sva u_spi_link_sva (.clk(clk), .rst_b(rst_b),
    .sclk(link.sclk), .chip_select_n(link.chip_select_n),
    .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe));
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (fifo_pop) pops <= pops + 8'h01;
    if (wr_valid) wr_seen <= 1'b1;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [23:0] exp, logic [23:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic xfer(row_t r);
    int k;
    k = 0;
    @(posedge clk);
    cur <= r;
    req <= 1'b1;
    wr_seen <= 1'b0;
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
    while (busy !== 1'b0 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k == 3000) begin
      n_errors++;
      end_sim();
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    chk("busy", 24'h0, {23'h0, busy});
    foreach (rows[i]) begin
      xfer(rows[i]);
      chk("write", {23'h0, rows[i].w}, {23'h0, wr_seen});
      if (rows[i].w) begin
        chk("wdata", {8'h0, rows[i].a, rows[i].d},
            {8'h0, wr_addr, wr_data});
      end else if (rows[i].n != 8'h00) begin
        chk("fifo", rows[i].ex, rx_word);
      end else begin
        chk("rdata", rows[i].ex, {16'h0, rx_word[7:0]});
      end
      $display("row %0d done", i);
    end
    cur <= '{8'h33, `CMD_WRITE, 8'h5A, 8'h00, 1'b1, 24'h0};
    wr_seen <= 1'b0;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    repeat (40) @(posedge clk);
    rst_b <= 1'b0;
    repeat (8) @(posedge clk);
    chk("cs", 24'h1, {23'h0, link.chip_select_n});
    chk("abort", 24'h0, {23'h0, wr_seen});
    rst_b <= 1'b1;
    xfer(rows[0]);
    chk("rewrite", 24'h1, {23'h0, wr_seen});
    chk("rewdata", {8'h0, rows[0].a, rows[0].d},
        {8'h0, wr_addr, wr_data});
    $display("reset test done");
    end_sim();
  end
endmodule
